// file: bench/tcb_core_props.sv
`timescale 1ns/1ps
module tcb_core_props
  import tcb_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Register port
  input wire logic [3:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic [7:0] io_rdata_out,
  // Timer pins and status
  input wire logic ext_clk_in,
  input wire logic capture_strobe_in,
  input wire logic [15:0] timer_count_value_out,
  input wire logic top_out,
  input wire logic bottom_out,
  input wire logic count_down_out,
  input wire logic counter_overflow_flag_out
);
  // ****
  // Shadow of the control fields
  // ****
  logic [4:0] ctl_b, next_ctl_b;
  logic [1:0] wgm_lo, next_wgm_lo;
  logic wr, wr_lo, wr_hi, rd_lo, rd_hi, stopped, normal;
  assign wr = clk_en_in && io_wr_in;
  assign wr_lo = wr && io_addr_in == ADDR_COUNT_LO;
  assign wr_hi = wr && io_addr_in == ADDR_COUNT_HI;
  assign rd_lo = clk_en_in && io_rd_in && io_addr_in == ADDR_COUNT_LO;
  assign rd_hi = clk_en_in && io_rd_in && io_addr_in == ADDR_COUNT_HI;
  assign stopped = ctl_b[2:0] == CS_STOP;
  assign normal = ctl_b[4:3] == 2'h0 && wgm_lo == 2'h0;
  always_comb begin
    next_ctl_b = ctl_b;
    next_wgm_lo = wgm_lo;
    if (wr && io_addr_in == ADDR_CTRL_B) next_ctl_b = io_wdata_in[4:0];
    if (wr && io_addr_in == ADDR_CTRL_A) next_wgm_lo = io_wdata_in[1:0];
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ctl_b <= 5'h00;
      wgm_lo <= 2'h0;
    end else begin
      ctl_b <= next_ctl_b;
      wgm_lo <= next_wgm_lo;
    end
  end
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_reset_clear: assert property ($rose(reset_n_in) |->
    timer_count_value_out == COUNT_RESET && bottom_out && !top_out)
    else $error("count not clear after reset");
  a_bottom_zero: assert property (
    bottom_out == (timer_count_value_out == COUNT_BOTTOM)) else $error("bottom flag wrong");
  a_lo_read: assert property (rd_lo |=>
    io_rdata_out == $past(timer_count_value_out[7:0])) else $error("lower byte read wrong");
  a_pair_read: assert property ((rd_lo ##1 rd_hi) |=>
    io_rdata_out == $past(timer_count_value_out[15:8], 2)) else $error("upper byte read wrong");
  a_pair_write: assert property ((wr_hi ##1 wr_lo) |=>
    timer_count_value_out == {$past(io_wdata_in, 2), $past(io_wdata_in)})
    else $error("paired write lost");
  a_stop_hold: assert property ((stopped && $past(stopped) && !wr_lo) |=>
    $stable(timer_count_value_out)) else $error("count moved while stopped");
  a_step_one: assert property (($changed(timer_count_value_out) && !$past(wr_lo)) |->
    timer_count_value_out == $past(timer_count_value_out) + 16'h0001
    || timer_count_value_out == $past(timer_count_value_out) - 16'h0001
    || timer_count_value_out == COUNT_BOTTOM) else $error("count step not one");
  a_ovf_wrap: assert property (($rose(counter_overflow_flag_out) && normal) |->
    ($past(timer_count_value_out) == COUNT_MAX || $past(timer_count_value_out, 2) == COUNT_MAX))
    else $error("overflow away from maximum");
  a_top_max: assert property ((normal && timer_count_value_out == COUNT_MAX) |-> top_out)
    else $error("top missing at maximum");
  c_pair_write: cover property (wr_hi ##1 wr_lo);
  c_overflow: cover property ($rose(counter_overflow_flag_out));
  c_down: cover property ($rose(count_down_out));
endmodule : tcb_core_props

bind tcb_core tcb_core_props i_tcb_core_props (
  .clk_in, .reset_n_in, .clk_en_in, .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in,
  .io_rdata_out, .ext_clk_in, .capture_strobe_in, .timer_count_value_out, .top_out,
  .bottom_out, .count_down_out, .counter_overflow_flag_out
);

// file: bench/tcb_core_tb.sv
`timescale 1ns/1ps
module tcb_core_tb
  import tcb_pkg::*;
;
  // ****
  // Harness
  // ****
  logic clk_in, reset_n_in, ext_clk_in, wr, rd, top, bot, down_out, ovf;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, b;
  logic [15:0] cnt, v;
  int n_mismatch = 0;
  int checks_done = 0;
  int dv[8] = '{1, 1, 8, 64, 256, 1024, 8, 8};

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  tcb_core i_tcb_core (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(1'b1), .io_addr_in(addr),
    .io_wr_in(wr), .io_rd_in(rd), .io_wdata_in(wdata), .io_rdata_out(rdata),
    .ext_clk_in(ext_clk_in), .capture_strobe_in(1'b0), .timer_count_value_out(cnt),
    .top_out(top), .bottom_out(bot), .count_down_out(down_out),
    .counter_overflow_flag_out(ovf)
  );
  tcb_cpu_model i_tcb_cpu_model (
    .clk_in(clk_in), .io_addr_out(addr), .io_wr_out(wr), .io_rd_out(rd),
    .io_wdata_out(wdata), .io_rdata_in(rdata)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // Follows the count tick by tick once the first tick has been seen
  task automatic run(input logic [3:0] m, input logic [15:0] s, input logic [15:0] tp,
                     input bit dual, input int n);
    logic [15:0] e;
    bit dn;
    int k;
    e = s;
    dn = 1'b0;
    k = 0;
    i_tcb_cpu_model.wr16(ADDR_COUNT_LO, s);
    i_tcb_cpu_model.wr8(ADDR_CTRL_A, {6'h00, m[1:0]});
    i_tcb_cpu_model.wr8(ADDR_CTRL_B, {3'h0, m[3:2], CS_DIV1});
    #1;
    while (cnt === s && k < 8) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    repeat (n) begin
      if (dual && !dn && e == tp) dn = 1'b1;
      else if (dual && dn && e == 16'h0000) dn = 1'b0;
      if (dn) e = e - 16'h0001;
      else e = (!dual && e == tp) ? 16'h0000 : e + 16'h0001;
      chk(cnt, e);
      chk(top, e == tp);
      chk(bot, e == 16'h0000);
      if (dual && e != tp && e != 16'h0000) chk(down_out, dn);
      @(posedge clk_in);
      #1;
    end
    i_tcb_cpu_model.wr8(ADDR_CTRL_B, 8'h00);
  endtask : run

  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    finish_test();
  end

  // ****
  // Tests
  // ****
  initial begin
    reset_n_in = 1'b0;
    ext_clk_in = 1'b0;
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    i_tcb_cpu_model.rd16(ADDR_COUNT_LO, v);
    chk(v, COUNT_RESET);
    chk(bot, 1'b1);
    i_tcb_cpu_model.wr16(ADDR_COUNT_LO, 16'h01ff);
    i_tcb_cpu_model.rd16(ADDR_COUNT_LO, v);
    chk(v, 16'h01ff);
    // One upper byte serves the counter and compare A
    i_tcb_cpu_model.op(1'b1, 1'b0, ADDR_COUNT_HI, 8'h12);
    i_tcb_cpu_model.op(1'b1, 1'b0, ADDR_COUNT_LO, 8'h34);
    i_tcb_cpu_model.wr8(ADDR_CMPA_LO, 8'h56);
    i_tcb_cpu_model.rd8(ADDR_CMPA_HI, b);
    chk(b, 8'h12);
    i_tcb_cpu_model.rd16(ADDR_COUNT_LO, v);
    chk(v, 16'h1234);
    i_tcb_cpu_model.wr8(ADDR_COUNT_HI, 8'hab);
    i_tcb_cpu_model.rd8(ADDR_COUNT_HI, b);
    chk(b, 8'hab);
    chk(cnt, 16'h1234);
    i_tcb_cpu_model.rd8(ADDR_CAPT_LO, b);
    i_tcb_cpu_model.rd8(ADDR_COUNT_HI, b);
    chk(b, 8'h00);
    i_tcb_cpu_model.rd8(4'hd, b);
    chk(b, 8'h00);
    run(4'h0, 16'hfff0, COUNT_MAX, 1'b0, 40);
    i_tcb_cpu_model.rd8(ADDR_FLAGS, b);
    chk(b[FLAG_OVF_BIT], 1'b1);
    chk(ovf, 1'b1);
    i_tcb_cpu_model.wr8(ADDR_FLAGS, 8'h01);
    i_tcb_cpu_model.rd8(ADDR_FLAGS, b);
    chk(b[FLAG_OVF_BIT], 1'b0);
    chk(ovf, 1'b0);
    run(4'h1, 16'h00f8, TOP_8BIT, 1'b1, 300);
    run(4'h5, 16'h00f0, TOP_8BIT, 1'b0, 30);
    // Compare A still holds 0x1256 and sets the top of this sequence
    run(4'h4, 16'h1250, 16'h1256, 1'b0, 20);
    // Write lands on a cycle that also carries a tick
    i_tcb_cpu_model.wr8(ADDR_CTRL_B, {5'h00, CS_DIV1});
    i_tcb_cpu_model.wr16(ADDR_COUNT_LO, 16'h4000);
    #1 chk(cnt, 16'h4000);
    // Stop before the source sweep so only the selected source adds ticks
    i_tcb_cpu_model.wr8(ADDR_CTRL_B, 8'h00);
    // Every source: about four ticks each, the stop write may add up to two
    for (int c = 1; c < 8; c++) begin
      i_tcb_cpu_model.wr16(ADDR_COUNT_LO, 16'h0000);
      i_tcb_cpu_model.wr8(ADDR_CTRL_B, {5'h00, c[2:0]});
      for (int k = 0; k < 4 * dv[c]; k++) begin
        @(posedge clk_in);
        ext_clk_in <= k[2];
      end
      i_tcb_cpu_model.wr8(ADDR_CTRL_B, 8'h00);
      i_tcb_cpu_model.rd16(ADDR_COUNT_LO, v);
      chk(v >= 16'h0003 && v <= 16'h0006, 1'b1);
    end
    finish_test();
  end
endmodule : tcb_core_tb

// file: bench/tcb_cpu_model.sv
`timescale 1ns/1ps
module tcb_cpu_model
  import tcb_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Register port
  output logic [3:0] io_addr_out,
  output logic io_wr_out,
  output logic io_rd_out,
  output logic [7:0] io_wdata_out,
  input wire logic [7:0] io_rdata_in
);
  // ****
  // Processor accesses, one per cycle
  // ****
  initial begin
    io_addr_out = 4'h0;
    io_wr_out = 1'b0;
    io_rd_out = 1'b0;
    io_wdata_out = 8'h00;
  end
  // Idle data lines toggle so a stale byte can never pass for a write
  task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    io_wr_out <= w;
    io_rd_out <= r;
    io_addr_out <= a;
    io_wdata_out <= w ? d : ~io_wdata_out;
  endtask : op
  task automatic idle();
    op(1'b0, 1'b0, 4'h0, 8'h00);
  endtask : idle
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
    idle();
  endtask : wr8
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    op(1'b0, 1'b1, a, 8'h00);
    idle();
    #1 d = io_rdata_in;
  endtask : rd8
  // Both halves back to back, nothing can slip in and disturb the latch
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    op(1'b1, 1'b0, a + 4'h1, v[15:8]);
    op(1'b1, 1'b0, a, v[7:0]);
    idle();
  endtask : wr16
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    op(1'b0, 1'b1, a, 8'h00);
    op(1'b0, 1'b1, a + 4'h1, 8'h00);
    #1 v[7:0] = io_rdata_in;
    idle();
    #1 v[15:8] = io_rdata_in;
  endtask : rd16
endmodule : tcb_cpu_model

// file: core/tcb_clock_select.sv
`timescale 1ns/1ps
module tcb_clock_select
  import tcb_pkg::*;
(
  // Clock and control
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Source selection
  input wire logic [2:0] clock_select_field_in,
  input wire logic ext_clk_in,
  // Timer tick, one cycle wide
  output logic timer_tick_out
);

  logic [9:0] prescale;
  logic [9:0] next_prescale;
  logic ext_prev;
  logic next_ext_prev;

  always_comb begin
    next_prescale = prescale + 10'h001;
    next_ext_prev = ext_clk_in;
    case (clock_select_field_in)
      CS_STOP: timer_tick_out = 1'b0;
      CS_DIV1: timer_tick_out = 1'b1;
      CS_DIV8: timer_tick_out = (prescale & PRE_MASK_8) == PRE_MASK_8;
      CS_DIV64: timer_tick_out = (prescale & PRE_MASK_64) == PRE_MASK_64;
      CS_DIV256: timer_tick_out = (prescale & PRE_MASK_256) == PRE_MASK_256;
      CS_DIV1024: timer_tick_out = (prescale & PRE_MASK_1024) == PRE_MASK_1024;
      CS_EXT_FALL: timer_tick_out = ext_prev && !ext_clk_in;
      CS_EXT_RISE: timer_tick_out = !ext_prev && ext_clk_in;
      default: timer_tick_out = 1'b0;
    endcase
  end

  // Prescaler runs free so that switching source never waits for a wrap
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      prescale <= 10'h000;
      ext_prev <= 1'b0;
    end else if (clk_en_in) begin
      prescale <= next_prescale;
      ext_prev <= next_ext_prev;
    end
  end

endmodule : tcb_clock_select

// file: core/tcb_core.sv
// Operation
// - Sixteen-bit counter that counts up or down.
// - Counter seen as two byte locations, upper and lower byte.
// - Upper-byte location accesses the shared latch, not the counter.
// - Reading lower byte copies counter upper byte into the latch that cycle.
// - Writing lower byte loads counter from latch plus written byte.
// - Whole sixteen-bit read or write takes effect in one clock.
// - Each timer tick clears, increments or decrements per mode.
// - Counting changes the value by exactly one in the current direction.
// - Internal direction state selects increment or decrement.
// - Clear forces every counter bit to zero.
// - Top indication when counter equals the sequence's highest value.
// - Bottom indication when counter equals zero.
// - Three-bit clock select in control B picks the tick source.
// - Clock select zero gives no tick; counter stops.
// - Counter readable and writable with or without ticks.
// - Processor write beats a same-cycle clear or count.
// - Four-bit waveform mode across control A and B sets sequence.
// - Overflow flag set where mode says; may drive an interrupt.
// - Latch holds across lower-byte writes; one upper byte serves many.
// - One latch shared by counter, both compare and capture registers.
// - Compare register reads return both bytes directly, no latch.
// - Counter maximum is 0xffff, bottom is 0x0000.
`timescale 1ns/1ps
module tcb_core
  import tcb_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Processor I/O port
  input wire logic [3:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  // Timer pins and events
  input wire logic ext_clk_in,
  input wire logic capture_strobe_in,
  // Status towards waveform and interrupt logic
  output logic [15:0] timer_count_value_out,
  output logic top_out,
  output logic bottom_out,
  output logic count_down_out,
  output logic counter_overflow_flag_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] control_reg_a;
  logic [7:0] control_reg_b;
  logic [15:0] count;
  logic [15:0] cmpa;
  logic [15:0] cmpb;
  logic [15:0] capt;
  logic ovf;
  tcb_slope_t slope;
  logic [7:0] next_control_reg_a;
  logic [7:0] next_control_reg_b;
  logic [15:0] next_count;
  logic [15:0] next_cmpa;
  logic [15:0] next_cmpb;
  logic [15:0] next_capt;
  logic next_ovf;
  tcb_slope_t next_slope;
  logic [7:0] next_rdata;
  logic next_top;
  logic next_bottom;

  // ****************************************************************
  // Decoded access and mode
  // ****************************************************************
  logic wr_count_lo;
  logic rd_count_lo;
  logic rd_capt_lo;
  logic wr_any_hi;
  logic tick;
  logic ovf_event;
  logic [7:0] latch;
  logic [7:0] snap_byte;
  logic [3:0] wgm;
  logic [2:0] clock_select_field;
  logic [15:0] top_value;
  tcb_kind_t kind;

  assign wgm = {control_reg_b[CTRLB_WGM_LSB+1:CTRLB_WGM_LSB],
                control_reg_a[CTRLA_WGM_LSB+1:CTRLA_WGM_LSB]};
  assign clock_select_field = control_reg_b[CTRLB_CS_LSB+2:CTRLB_CS_LSB];
  assign top_value = tcb_mode_top(wgm, cmpa, capt);
  assign kind = tcb_mode_kind(wgm);

  assign wr_count_lo = io_wr_in && (io_addr_in == ADDR_COUNT_LO);
  assign rd_count_lo = io_rd_in && (io_addr_in == ADDR_COUNT_LO);
  assign rd_capt_lo = io_rd_in && (io_addr_in == ADDR_CAPT_LO);
  // Every upper-byte write lands in the one shared latch
  assign wr_any_hi = io_wr_in && ((io_addr_in == ADDR_COUNT_HI) ||
                                  (io_addr_in == ADDR_CAPT_HI) ||
                                  (io_addr_in == ADDR_CMPA_HI) ||
                                  (io_addr_in == ADDR_CMPB_HI));
  // Capture low read borrows the latch the same way a counter low read does
  assign snap_byte = rd_capt_lo ? capt[15:8] : count[15:8];

  // ****************************************************************
  // Tick source and shared latch
  // ****************************************************************
  // A new clock select acts from the edge after its write
  tcb_clock_select u_clock_select (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .clock_select_field_in(clock_select_field),
    .ext_clk_in(ext_clk_in),
    .timer_tick_out(tick)
  );

  // Snapshot load has priority; with one access a cycle the two never meet
  tcb_high_latch u_high_latch (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .load_cpu_in(wr_any_hi),
    .cpu_byte_in(io_wdata_in),
    .load_snap_in(rd_count_lo || rd_capt_lo),
    .snap_byte_in(snap_byte),
    .latch_out(latch)
  );

  // ****************************************************************
  // Counter sequence
  // ****************************************************************
  always_comb begin
    next_count = count;
    next_slope = slope;
    ovf_event = 1'b0;
    if (wr_count_lo) begin
      // A lost tick is the price of letting software own the value
      next_count = {latch, io_wdata_in};
    end else if (tick) begin
      case (kind)
        KIND_LINEAR: begin
          next_slope = SLOPE_UP;
          ovf_event = (count == COUNT_MAX);
          if (count == top_value) begin
            next_count = COUNT_BOTTOM;
          end else begin
            next_count = count + 16'h0001;
          end
        end
        KIND_FAST: begin
          next_slope = SLOPE_UP;
          ovf_event = (count >= top_value);
          if (count >= top_value) begin
            next_count = COUNT_BOTTOM;
          end else begin
            next_count = count + 16'h0001;
          end
        end
        KIND_DUAL: begin
          case (slope)
            SLOPE_UP: begin
              if (count >= top_value) begin
                next_slope = SLOPE_DOWN;
                next_count = count - 16'h0001;
              end else begin
                next_count = count + 16'h0001;
              end
            end
            SLOPE_DOWN: begin
              if (count == COUNT_BOTTOM) begin
                ovf_event = 1'b1;
                next_slope = SLOPE_UP;
                next_count = count + 16'h0001;
              end else begin
                next_count = count - 16'h0001;
              end
            end
            default: begin
              next_slope = SLOPE_UP;
            end
          endcase
        end
        default: begin
          next_count = count;
        end
      endcase
    end
  end

  // ****************************************************************
  // Register file writes and overflow flag
  // ****************************************************************
  always_comb begin
    next_control_reg_a = control_reg_a;
    next_control_reg_b = control_reg_b;
    next_cmpa = cmpa;
    next_cmpb = cmpb;
    next_capt = capt;
    next_ovf = ovf;
    if (io_wr_in) begin
      case (io_addr_in)
        ADDR_CTRL_A: next_control_reg_a = io_wdata_in;
        ADDR_CTRL_B: next_control_reg_b = io_wdata_in;
        // Compare loads are immediate; a top taken from them is not double buffered
        ADDR_CMPA_LO: next_cmpa = {latch, io_wdata_in};
        ADDR_CMPB_LO: next_cmpb = {latch, io_wdata_in};
        ADDR_CAPT_LO: begin
          // Capture register is writable only while it defines the top
          if (tcb_capt_is_top(wgm)) begin
            next_capt = {latch, io_wdata_in};
          end
        end
        ADDR_FLAGS: begin
          if (io_wdata_in[FLAG_OVF_BIT]) begin
            next_ovf = 1'b0;
          end
        end
        default: begin
          next_ovf = ovf;
        end
      endcase
    end
    if (capture_strobe_in && !tcb_capt_is_top(wgm)) begin
      next_capt = count;
    end
    // Set placed last so a same-cycle clear cannot swallow the event
    if (ovf_event) begin
      next_ovf = 1'b1;
    end
  end

  // ****************************************************************
  // Read data and indications
  // ****************************************************************
  always_comb begin
    next_rdata = io_rdata_out;
    // Compare reads bypass the latch, so they never disturb a pending pair
    if (io_rd_in) begin
      case (io_addr_in)
        ADDR_CTRL_A: next_rdata = control_reg_a;
        ADDR_CTRL_B: next_rdata = control_reg_b;
        ADDR_COUNT_LO: next_rdata = count[7:0];
        ADDR_COUNT_HI: next_rdata = latch;
        ADDR_CAPT_LO: next_rdata = capt[7:0];
        ADDR_CAPT_HI: next_rdata = latch;
        ADDR_CMPA_LO: next_rdata = cmpa[7:0];
        ADDR_CMPA_HI: next_rdata = cmpa[15:8];
        ADDR_CMPB_LO: next_rdata = cmpb[7:0];
        ADDR_CMPB_HI: next_rdata = cmpb[15:8];
        ADDR_FLAGS: next_rdata = {7'h00, ovf};
        default: next_rdata = 8'h00;
      endcase
    end
    // Indications follow the value and mode that will stand next cycle
    next_top = (next_count == tcb_mode_top({next_control_reg_b[CTRLB_WGM_LSB+1:CTRLB_WGM_LSB],
                next_control_reg_a[CTRLA_WGM_LSB+1:CTRLA_WGM_LSB]},
                next_cmpa, next_capt));
    next_bottom = (next_count == COUNT_BOTTOM);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      control_reg_a <= CTRL_A_RESET;
      control_reg_b <= CTRL_B_RESET;
      count <= COUNT_RESET;
      cmpa <= CMP_RESET;
      cmpb <= CMP_RESET;
      capt <= CAPT_RESET;
      ovf <= 1'b0;
      slope <= SLOPE_UP;
      io_rdata_out <= RDATA_RESET;
      top_out <= 1'b0;
      bottom_out <= 1'b1;
      timer_count_value_out <= COUNT_RESET;
      count_down_out <= 1'b0;
      counter_overflow_flag_out <= 1'b0;
    end else if (clk_en_in) begin
      control_reg_a <= next_control_reg_a;
      control_reg_b <= next_control_reg_b;
      count <= next_count;
      cmpa <= next_cmpa;
      cmpb <= next_cmpb;
      capt <= next_capt;
      ovf <= next_ovf;
      slope <= next_slope;
      io_rdata_out <= next_rdata;
      top_out <= next_top;
      bottom_out <= next_bottom;
      timer_count_value_out <= next_count;
      count_down_out <= (next_slope == SLOPE_DOWN);
      counter_overflow_flag_out <= next_ovf;
    end
  end

endmodule : tcb_core

// file: core/tcb_high_latch.sv
`timescale 1ns/1ps
module tcb_high_latch
  import tcb_pkg::*;
(
  // Clock and control
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Loads
  input wire logic load_cpu_in,
  input wire logic [7:0] cpu_byte_in,
  input wire logic load_snap_in,
  input wire logic [7:0] snap_byte_in,
  // Held byte
  output logic [7:0] latch_out
);

  logic [7:0] next_latch;

  // Only loads change it, so one high byte can serve several low-byte writes
  always_comb begin
    next_latch = latch_out;
    if (load_snap_in) begin
      next_latch = snap_byte_in;
    end else if (load_cpu_in) begin
      next_latch = cpu_byte_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      latch_out <= LATCH_RESET;
    end else if (clk_en_in) begin
      latch_out <= next_latch;
    end
  end

endmodule : tcb_high_latch

// file: core/tcb_pkg.sv
package tcb_pkg;

  // ****************************************************************
  // Register indices on the 8-bit I/O port
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] ADDR_COUNT_LO = 4'h4;
  localparam logic [3:0] ADDR_COUNT_HI = 4'h5;
  localparam logic [3:0] ADDR_CAPT_LO = 4'h6;
  localparam logic [3:0] ADDR_CAPT_HI = 4'h7;
  localparam logic [3:0] ADDR_CMPA_LO = 4'h8;
  localparam logic [3:0] ADDR_CMPA_HI = 4'h9;
  localparam logic [3:0] ADDR_CMPB_LO = 4'ha;
  localparam logic [3:0] ADDR_CMPB_HI = 4'hb;
  localparam logic [3:0] ADDR_FLAGS = 4'hc;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRLA_WGM_LSB = 0;
  localparam int CTRLB_CS_LSB = 0;
  localparam int CTRLB_WGM_LSB = 3;
  localparam int FLAG_OVF_BIT = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [15:0] CAPT_RESET = 16'h0000;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ****************************************************************
  // Count limits
  // ****************************************************************
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;

  // ****************************************************************
  // Clock select codes and prescaler masks
  // ****************************************************************
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03f;
  localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    SLOPE_UP = 2'b01,
    SLOPE_DOWN = 2'b10
  } tcb_slope_t;

  typedef enum logic [2:0] {
    KIND_LINEAR = 3'b001,
    KIND_FAST = 3'b010,
    KIND_DUAL = 3'b100
  } tcb_kind_t;

  // ****************************************************************
  // Mode decoding
  // ****************************************************************
  function automatic logic [15:0] tcb_mode_top(input logic [3:0] wgm,
                                               input logic [15:0] cmpa,
                                               input logic [15:0] capt);
    case (wgm)
      4'h1, 4'h5: tcb_mode_top = TOP_8BIT;
      4'h2, 4'h6: tcb_mode_top = TOP_9BIT;
      4'h3, 4'h7: tcb_mode_top = TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: tcb_mode_top = cmpa;
      4'h8, 4'ha, 4'hc, 4'he: tcb_mode_top = capt;
      default: tcb_mode_top = COUNT_MAX;
    endcase
  endfunction : tcb_mode_top

  function automatic tcb_kind_t tcb_mode_kind(input logic [3:0] wgm);
    case (wgm)
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: tcb_mode_kind = KIND_FAST;
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: tcb_mode_kind = KIND_DUAL;
      default: tcb_mode_kind = KIND_LINEAR;
    endcase
  endfunction : tcb_mode_kind

  function automatic logic tcb_capt_is_top(input logic [3:0] wgm);
    tcb_capt_is_top = (wgm == 4'h8) || (wgm == 4'ha) || (wgm == 4'hc) || (wgm == 4'he);
  endfunction : tcb_capt_is_top

endpackage : tcb_pkg
